// ===== float_status_pkg.sv
/*
  constants and field layout for the floating status and exception control block.
  assumes a single processor clock and a sequencer that drives one-cycle event pulses.
*/
// What this block does
// RL1: error flag set on qualifying floating exceptions
// RL2: only status load clears the error flag
// RL3: global disable suppresses every floating interrupt
// RL4: status bits 13 and 12 reserved
// RL5: trap on negative zero memory operand
// RL6: no trap for accumulator negative zero
// RL7: trap enable clear lets negative zero pass
// RL8: enabled underflow interrupts, exponent wraps by 400
// RL9: enabled overflow interrupts, exponent wraps by 400
// RL10: disabled overflow returns exact zero
// RL11: enabled conversion failure interrupts, destination zero
// RL12: disabled conversion failure gives zero, no interrupt
// RL13: conversion fails if integer exceeds selected width
// RL14: precision bit selects double or single
// RL15: long integer bit selects 32 or 16
// RL16: six exceptions, four individually enabled
// RL17: hardware updates error flag and condition codes
// RL18: modes apply now, codes show previous result
// RL19: chop bit truncates, otherwise round
// RL20: bits 3 to 0 hold result flags
// RL21: single vector 244, 4-bit exception code
// RL22: trap request held until acknowledged
package float_status_pkg;
  localparam int STATUS_W = 16;
  localparam int BIT_ERR  = 15;
  localparam int BIT_DIS  = 14;
  localparam int BIT_UV   = 11;
  localparam int BIT_UND  = 10;
  localparam int BIT_OVF  = 9;
  localparam int BIT_CNV  = 8;
  localparam int BIT_DBL  = 7;
  localparam int BIT_LNG  = 6;
  localparam int BIT_CHOP = 5;
  localparam int BIT_NEG  = 3;
  localparam int BIT_ZERO = 2;
  localparam int BIT_VFL  = 1;
  localparam int BIT_CRY  = 0;
  // bits 13, 12 and 4 hold nothing and read as zero
  localparam logic [15:0] WRITE_MASK   = 16'hCFEF;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam int FRAC_W  = 55;
  localparam int EXP_W   = 8;
  localparam int RAWEXP_W = 10;
  localparam int SINGLE_LOW = 32;
  localparam int SHORT_INT_W = 16;
  localparam int LONG_INT_W  = 32;
  localparam int CONV_W  = 40;
  localparam logic [EXP_W-1:0] EXP_MAX = 8'hFF;
  localparam logic [8:0] TRAP_VECTOR = 9'h0A4;
  localparam logic [3:0] CODE_NONE   = 4'h0;
  localparam logic [3:0] CODE_OPCODE = 4'h2;
  localparam logic [3:0] CODE_DIVZ   = 4'h4;
  localparam logic [3:0] CODE_CONV   = 4'h6;
  localparam logic [3:0] CODE_OVF    = 4'h8;
  localparam logic [3:0] CODE_UND    = 4'hA;
  localparam logic [3:0] CODE_UNDEF  = 4'hC;
endpackage

// ===== result_fixup_if.sv
/*
  carrier between the status block and its result fixup stage.
  assumes both ends sit in the same clock domain.
*/
interface result_fixup_if;
  import float_status_pkg::*;
  logic                rawSign;
  logic [RAWEXP_W-1:0] rawExp;
  logic [FRAC_W-1:0]   rawFrac;
  logic                rawRoundBit;
  logic                chopMode;
  logic                doubleMode;
  logic                ovfEnable;
  logic                undEnable;
  logic                overflow;
  logic                underflow;
  logic [63:0]         storedWord;
  modport control (output rawSign, rawExp, rawFrac, rawRoundBit, chopMode,
                   doubleMode, ovfEnable, undEnable, input overflow, underflow, storedWord);
  modport fixup   (input rawSign, rawExp, rawFrac, rawRoundBit, chopMode,
                   doubleMode, ovfEnable, undEnable, output overflow, underflow, storedWord);
endinterface

// ===== result_fixup.sv
/*
  combinational rounding and exponent range fixup of an arithmetic result.
  assumes the raw exponent is the biased exponent as a signed ten-bit value.
*/
module result_fixup
  import float_status_pkg::*;
(
  result_fixup_if.fixup port
);
  logic [FRAC_W-1:0] addend;
  logic [FRAC_W-1:0] rounded;
  logic              roundUp;
  logic              zeroOut;

  always_comb begin
    // ----------------------------------------------------------
    // rounding
    // ----------------------------------------------------------
    roundUp = !port.chopMode
              && (port.doubleMode ? port.rawRoundBit : port.rawFrac[SINGLE_LOW-1]); // RL19
    addend  = port.doubleMode ? FRAC_W'(1) : (FRAC_W'(1) << SINGLE_LOW);              // RL14
    // carry out of the fraction is dropped; the sequencer renormalises first
    rounded = roundUp ? port.rawFrac + addend : port.rawFrac;
    if (!port.doubleMode) begin
      rounded[SINGLE_LOW-1:0] = '0; // RL14
    end
    // ----------------------------------------------------------
    // range check
    // ----------------------------------------------------------
    port.overflow  = !port.rawExp[RAWEXP_W-1] && (port.rawExp > RAWEXP_W'(EXP_MAX));
    port.underflow = port.rawExp[RAWEXP_W-1] || (port.rawExp == '0 && rounded != '0);
    // disabled range errors store clean zero so no negative zero escapes
    zeroOut = (port.overflow && !port.ovfEnable) || (port.underflow && !port.undEnable)
              || (port.rawExp == '0 && !port.underflow); // RL10 RL6
    // enabled errors keep the low exponent bits, i.e. off by 400 octal
    port.storedWord = zeroOut ? 64'h0000_0000_0000_0000
                      : {port.rawSign, port.rawExp[EXP_W-1:0], rounded}; // RL8 RL9
  end
endmodule

// ===== float_status_exception_control.sv
/*
  floating status and control word, exception recording and trap request.
  assumes the sequencer gives one-cycle pulses for events and results,
  and holds trapAck until it sees trapRequest fall.
*/
module float_status_exception_control
  import float_status_pkg::*;
#(
  parameter int CONV_WIDTH = float_status_pkg::CONV_W
)(
  input  wire logic                                  sys_clk,
  input  wire logic                                  reset,
  input  wire logic                                  loadStrobe,
  input  wire logic [float_status_pkg::STATUS_W-1:0] loadData,
  output logic      [float_status_pkg::STATUS_W-1:0] statusWord,
  input  wire logic                                  opcodeIllegal,
  input  wire logic                                  divideByZero,
  input  wire logic                                  operandValid,
  input  wire logic                                  operandFromMemory,
  input  wire logic [15:0]                           operandHigh,
  input  wire logic                                  resultValid,
  input  wire logic                                  rawSign,
  input  wire logic [float_status_pkg::RAWEXP_W-1:0] rawExp,
  input  wire logic [float_status_pkg::FRAC_W-1:0]   rawFrac,
  input  wire logic                                  rawRoundBit,
  input  wire logic                                  convValid,
  input  wire logic [CONV_WIDTH-1:0]                 convValue,
  output logic      [63:0]                           storedResult,
  output logic      [31:0]                           convResult,
  output logic      [3:0]                            exceptionCode,
  output logic                                       trapRequest,
  input  wire logic                                  trapAck,
  output logic      [8:0]                            trapVector,
  output logic                                       doublePrecision,
  output logic                                       longInteger,
  output logic                                       chopMode
);
  import float_status_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [STATUS_W-1:0] status_reg;
  logic [STATUS_W-1:0] status_next;
  logic [3:0]          code_reg;
  logic [3:0]          code_next;
  logic                trap_reg;
  logic                trap_next;
  logic [63:0]         result_reg;
  logic [63:0]         result_next;
  logic [31:0]         conv_reg;
  logic [31:0]         conv_next;

  logic undefSeen;
  logic convFail;
  logic shortFit;
  logic longFit;
  logic uvEnable;
  logic allDisable;
  logic qualifying;
  logic [3:0] eventCode;

  result_fixup_if fx ();

  result_fixup fixupUnit (
    .port (fx.fixup)
  );

  // ------------------------------------------------------------
  // mode outputs, taken by the instruction now executing
  // ------------------------------------------------------------
  assign doublePrecision = status_reg[BIT_DBL]; // RL14 RL18
  assign longInteger     = status_reg[BIT_LNG]; // RL15
  assign chopMode        = status_reg[BIT_CHOP]; // RL19
  assign uvEnable        = status_reg[BIT_UV];
  assign allDisable      = status_reg[BIT_DIS];

  assign fx.rawSign     = rawSign;
  assign fx.rawExp      = rawExp;
  assign fx.rawFrac     = rawFrac;
  assign fx.rawRoundBit = rawRoundBit;
  assign fx.chopMode    = chopMode;
  assign fx.doubleMode  = doublePrecision;
  assign fx.ovfEnable   = status_reg[BIT_OVF];
  assign fx.undEnable   = status_reg[BIT_UND];

  assign statusWord    = status_reg & WRITE_MASK; // RL4
  assign storedResult  = result_reg;
  assign convResult    = conv_reg;
  assign exceptionCode = code_reg;
  assign trapRequest   = trap_reg;
  assign trapVector    = TRAP_VECTOR; // RL21

  // ------------------------------------------------------------
  // exception detection
  // ------------------------------------------------------------
  always_comb begin
    // negative zero: sign set, biased exponent zero, from memory only
    undefSeen = operandValid && operandFromMemory && uvEnable
                && operandHigh[15] && operandHigh[14:7] == '0; // RL5 RL6 RL7
    // an integer fits n bits when all bits above n-1 copy the sign
    shortFit = (convValue[CONV_WIDTH-1:SHORT_INT_W-1] == '0)
               || (&convValue[CONV_WIDTH-1:SHORT_INT_W-1]);
    longFit  = (convValue[CONV_WIDTH-1:LONG_INT_W-1] == '0)
               || (&convValue[CONV_WIDTH-1:LONG_INT_W-1]);
    convFail = convValid && !(longInteger ? longFit : shortFit); // RL13 RL15
    // first match wins when several land together
    eventCode = CODE_NONE;
    if (opcodeIllegal) begin
      eventCode = CODE_OPCODE; // RL16
    end else if (divideByZero) begin
      eventCode = CODE_DIVZ;
    end else if (undefSeen) begin
      eventCode = CODE_UNDEF;
    end else if (convFail && status_reg[BIT_CNV]) begin
      eventCode = CODE_CONV; // RL11 RL12
    end else if (resultValid && fx.overflow && status_reg[BIT_OVF]) begin
      eventCode = CODE_OVF; // RL9
    end else if (resultValid && fx.underflow && status_reg[BIT_UND]) begin
      eventCode = CODE_UND; // RL8
    end
    qualifying = eventCode != CODE_NONE; // RL1 RL16
  end

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  always_comb begin
    status_next = status_reg;
    code_next   = code_reg;
    trap_next   = trap_reg;
    result_next = result_reg;
    conv_next   = conv_reg;
    if (loadStrobe) begin
      status_next = loadData & WRITE_MASK; // RL17 RL2 RL4
    end
    if (resultValid) begin
      result_next = fx.storedWord;
      status_next[BIT_NEG]  = fx.storedWord[63]; // RL20
      status_next[BIT_ZERO] = fx.storedWord[62 -: EXP_W] == '0;
      status_next[BIT_VFL]  = fx.overflow;
      status_next[BIT_CRY]  = 1'b0;
    end else if (convValid) begin
      // failed conversions always yield zero, the enable gates the error flag, code and trap
      conv_next = convFail ? 32'h0000_0000 : convValue[31:0]; // RL11 RL12
      if (!longInteger) begin
        conv_next[31:SHORT_INT_W] = '0;
      end
      status_next[BIT_NEG]  = !convFail && convValue[CONV_WIDTH-1]; // RL20
      status_next[BIT_ZERO] = convFail || convValue == '0;
      status_next[BIT_VFL]  = 1'b0;
      status_next[BIT_CRY]  = convFail;
    end
    if (qualifying) begin
      // a same-cycle load cannot wipe out a fresh error
      status_next[BIT_ERR] = 1'b1; // RL1 RL2
      code_next = eventCode; // RL21
    end
    if (trapAck) begin
      trap_next = 1'b0; // RL22
    end
    if (qualifying && !allDisable) begin
      trap_next = 1'b1; // RL3 RL22
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_reg <= STATUS_RESET;
      code_reg   <= CODE_NONE;
      trap_reg   <= 1'b0;
      result_reg <= 64'h0000_0000_0000_0000;
      conv_reg   <= 32'h0000_0000;
    end else begin
      status_reg <= status_next;
      code_reg   <= code_next;
      trap_reg   <= trap_next;
      result_reg <= result_next;
      conv_reg   <= conv_next;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_err_sticky: assert property ( // RL2
    status_reg[BIT_ERR] && !loadStrobe |=> status_reg[BIT_ERR])
    else $error("error flag dropped without a status load");

  a_err_set: assert property ( // RL1
    (opcodeIllegal || divideByZero) |=> status_reg[BIT_ERR] && code_reg != CODE_NONE)
    else $error("error flag not set by mandatory exception");

  a_disable_quiet: assert property ( // RL3
    $rose(trap_reg) |-> !$past(allDisable))
    else $error("trap raised while all interrupts disabled");

  a_reserved_zero: assert property ( // RL4
    statusWord[13:12] == 2'h0 && statusWord[4] == 1'b0)
    else $error("reserved status bit reads nonzero");

  a_acc_no_trap: assert property ( // RL6
    operandValid && !operandFromMemory && !opcodeIllegal && !divideByZero
    && !convValid && !resultValid |=> $stable(code_reg))
    else $error("accumulator operand changed the exception code");

  a_ovf_zero: assert property ( // RL10
    resultValid && !rawExp[RAWEXP_W-1] && rawExp > RAWEXP_W'(EXP_MAX)
    && !status_reg[BIT_OVF] && !qualifying |=> result_reg == 64'h0 && !$rose(trap_reg))
    else $error("disabled overflow did not return exact zero");

  a_conv_zero: assert property ( // RL11
    convFail && !resultValid |=> conv_reg == 32'h0 && status_reg[BIT_CRY]
    && (status_reg[BIT_ERR] || !$past(status_reg[BIT_CNV])))
    else $error("failed conversion left nonzero destination");

  a_trap_hold: assert property ( // RL22
    trap_reg && !trapAck |=> trap_reg)
    else $error("trap request dropped before acknowledge");

  a_zero_flag: assert property ( // RL20
    resultValid |=> status_reg[BIT_ZERO] == (result_reg[62 -: EXP_W] == '0))
    else $error("zero flag does not match stored result");

  a_undef_trap: assert property ( // RL5
    undefSeen && !opcodeIllegal && !divideByZero && !allDisable
    |=> trap_reg && code_reg == CODE_UNDEF)
    else $error("negative zero operand did not trap");

  a_uv_err: assert property ( // RL5
    undefSeen && !opcodeIllegal && !divideByZero |=> status_reg[BIT_ERR])
    else $error("negative zero operand did not set the error flag");

  a_mode_hold: assert property ( // RL17
    !loadStrobe |=> $stable(status_reg[BIT_DIS:BIT_CHOP]))
    else $error("mode or enable bit moved without a status load");

  a_opcode_first: assert property ( // RL16
    opcodeIllegal |=> code_reg == CODE_OPCODE)
    else $error("illegal opcode not recorded first");

  a_divz_code: assert property ( // RL21
    divideByZero && !opcodeIllegal |=> code_reg == CODE_DIVZ)
    else $error("divide by zero code not recorded");

  a_trap_code: assert property ( // RL1
    $rose(trap_reg) |-> status_reg[BIT_ERR] && code_reg != CODE_NONE)
    else $error("trap raised without error flag and code");

  a_disabled_record: assert property ( // RL3
    (opcodeIllegal || divideByZero) && allDisable
    |=> status_reg[BIT_ERR] && !$rose(trap_reg))
    else $error("global disable blocked recording or let a trap through");

  a_uv_off: assert property ( // RL7
    operandValid && operandFromMemory && !uvEnable && !opcodeIllegal && !divideByZero
    && !convValid && !resultValid |=> $stable(code_reg) && !$rose(trap_reg))
    else $error("negative zero trapped with its enable clear");

  a_conv_quiet: assert property ( // RL12
    convFail && !status_reg[BIT_CNV] && !opcodeIllegal && !divideByZero && !undefSeen
    && !resultValid |=> conv_reg == 32'h0 && !$rose(trap_reg))
    else $error("disabled conversion failure trapped or left data");

  a_ovf_wrap: assert property ( // RL9
    resultValid && fx.overflow && status_reg[BIT_OVF]
    |=> result_reg[62 -: EXP_W] == EXP_W'($past(rawExp)) && status_reg[BIT_VFL])
    else $error("enabled overflow stored a wrong exponent");

  a_und_wrap: assert property ( // RL8
    resultValid && fx.underflow && status_reg[BIT_UND]
    |=> result_reg[62 -: EXP_W] == EXP_W'($past(rawExp)))
    else $error("enabled underflow stored a wrong exponent");

  a_und_zero: assert property ( // RL6
    resultValid && fx.underflow && !status_reg[BIT_UND] |=> result_reg == 64'h0)
    else $error("disabled underflow did not store exact zero");

  a_single_low: assert property ( // RL14
    resultValid && !doublePrecision |=> result_reg[SINGLE_LOW-1:0] == '0)
    else $error("single precision result kept low fraction bits");

  a_chop_exact: assert property ( // RL19
    resultValid && chopMode && doublePrecision && !fx.overflow && !fx.underflow
    && rawExp != '0 |=> result_reg[FRAC_W-1:0] == $past(rawFrac))
    else $error("chopped result was altered");

  a_short_conv: assert property ( // RL15
    convValid && !resultValid && !longInteger
    |=> conv_reg[LONG_INT_W-1:SHORT_INT_W] == '0)
    else $error("short conversion left upper destination bits");

  a_ack_clears: assert property ( // RL22
    trap_reg && trapAck && !qualifying |=> !trap_reg)
    else $error("trap request held after acknowledge");

  a_neg_flag: assert property ( // RL20
    resultValid |=> status_reg[BIT_NEG] == result_reg[63] && !status_reg[BIT_CRY])
    else $error("result sign or carry flag wrong");

  a_conv_flags: assert property ( // RL20
    convValid && !resultValid |=> status_reg[BIT_CRY] == $past(convFail)
    && !status_reg[BIT_VFL])
    else $error("conversion condition codes wrong");

endmodule

// ===== trap_ack_model.sv
/*
  core sequencer side of the trap handshake.
  assumes trapRequest is a registered level on sys_clk.
*/
module trap_ack_model (
  input  wire logic       sys_clk,
  input  wire logic       trapRequest,
  input  wire logic [3:0] ackDelay,
  output logic            trapAck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] waitCount;
  logic       seenRequest;
  initial begin
    trapAck   = 1'b0;
    waitCount = 4'h0;
  end
  // the edge's own value is taken first, so a fresh request waits a cycle
  always @(posedge sys_clk) begin
    seenRequest = trapRequest;
    #1;
    if (!seenRequest) begin
      trapAck   = 1'b0;
      waitCount = 4'h0;
    end else if (waitCount >= ackDelay) begin
      trapAck = 1'b1;
    end else begin
      waitCount = waitCount + 4'h1;
    end
  end
endmodule

// ===== float_status_exception_control_bench.sv
/*
  self-checking bench for the floating status and exception block.
  assumes the package defaults and the trap_ack_model partner.
*/
module float_status_exception_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import float_status_pkg::*;
  logic sys_clk, reset, loadStrobe, opcodeIllegal, divideByZero, operandValid;
  logic operandFromMemory, resultValid, rawSign, rawRoundBit, convValid;
  logic trapRequest, trapAck, doublePrecision, longInteger, chopMode;
  logic [15:0]         loadData, statusWord, operandHigh;
  logic [RAWEXP_W-1:0] rawExp;
  logic [FRAC_W-1:0]   rawFrac;
  logic [CONV_W-1:0]   convValue;
  logic [63:0]         storedResult;
  logic [31:0]         convResult;
  logic [3:0]          exceptionCode, ackDelay;
  logic [8:0]          trapVector;
  int                  mismatches, cmp_count;
  float_status_exception_control u_dut (.sys_clk, .reset, .loadStrobe, .loadData,
    .statusWord, .opcodeIllegal, .divideByZero, .operandValid, .operandFromMemory,
    .operandHigh, .resultValid, .rawSign, .rawExp, .rawFrac, .rawRoundBit, .convValid,
    .convValue, .storedResult, .convResult, .exceptionCode, .trapRequest, .trapAck,
    .trapVector, .doublePrecision, .longInteger, .chopMode);
  trap_ack_model u_core (.sys_clk, .trapRequest, .ackDelay, .trapAck);
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic load(input logic [15:0] d);
    loadData = d;
    loadStrobe = 1'b1;
    tick;
    loadStrobe = 1'b0;
  endtask
  task automatic result(input logic s, input logic [9:0] e, input logic [54:0] f,
                        input logic r);
    rawSign = s;
    rawExp = e;
    rawFrac = f;
    rawRoundBit = r;
    resultValid = 1'b1;
    tick;
    resultValid = 1'b0;
  endtask
  task automatic conv(input logic [39:0] v);
    convValue = v;
    convValid = 1'b1;
    tick;
    convValid = 1'b0;
  endtask
  task automatic operand(input logic [15:0] h, input logic mem);
    operandHigh = h;
    operandFromMemory = mem;
    operandValid = 1'b1;
    tick;
    operandValid = 1'b0;
  endtask
  // error flag, code and trap level, then let the core take the trap
  task automatic outcome(input logic err, input logic [3:0] code, input logic trap);
    int i;
    check(statusWord[15], err);
    check(exceptionCode, code);
    check(trapRequest, trap);
    for (i = 0; i < 20 && trapRequest !== 1'b0; i++) tick;
    if (trapRequest !== 1'b0) begin
      mismatches++;
      complete_run;
    end
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    {reset, loadStrobe, opcodeIllegal, divideByZero, operandValid} = 5'h10;
    {operandFromMemory, resultValid, rawSign, rawRoundBit, convValid} = 5'h00;
    {loadData, operandHigh, rawExp, rawFrac, convValue} = '0;
    ackDelay = 4'h1;
    mismatches = 0;
    cmp_count = 0;
    repeat (10) tick;
    reset = 1'b0;
    check(statusWord, 16'h0000);
    check(trapVector, 9'h0A4);
    load(16'hFFFF);
    check(statusWord, 16'hCFEF);
    check({doublePrecision, longInteger, chopMode}, 3'h7);
    $display("test status load done");
    load(16'h0800);
    divideByZero = 1'b1;
    tick;
    divideByZero = 1'b0;
    outcome(1'b1, CODE_DIVZ, 1'b1);
    result(1'b0, 10'h081, 55'h0, 1'b0);
    check(statusWord[15], 1'b1);
    check(statusWord[3:0], 4'h0);
    load(16'h0800);
    operand(16'h8000, 1'b0);
    outcome(1'b0, CODE_DIVZ, 1'b0);
    load(16'h0000);
    operand(16'h8000, 1'b1);
    outcome(1'b0, CODE_DIVZ, 1'b0);
    ackDelay = 4'h5;
    load(16'h0800);
    operand(16'h8000, 1'b1);
    repeat (3) tick;
    outcome(1'b1, CODE_UNDEF, 1'b1);
    load(16'h4000);
    opcodeIllegal = 1'b1;
    tick;
    opcodeIllegal = 1'b0;
    outcome(1'b1, CODE_OPCODE, 1'b0);
    $display("test exceptions done");
    load(16'h0100);
    conv(40'h0000010000);
    outcome(1'b1, CODE_CONV, 1'b1);
    check(convResult, 32'h0);
    check(statusWord[3:0], 4'h5);
    load(16'h0000);
    conv(40'h0000010000);
    outcome(1'b0, CODE_CONV, 1'b0);
    check(convResult, 32'h0);
    conv(40'hFFFFFF8000);
    check(convResult, 32'h00008000);
    load(16'h0040);
    conv(40'h0000010000);
    check(convResult, 32'h00010000);
    $display("test conversion done");
    load(16'h0280);
    result(1'b0, 10'h105, 55'h1234, 1'b0);
    check(storedResult[62:55], 8'h05);
    check(storedResult[54:0], 55'h1234);
    check(statusWord[3:0], 4'h2);
    outcome(1'b1, CODE_OVF, 1'b1);
    load(16'h0080);
    result(1'b0, 10'h105, 55'h1234, 1'b0);
    check(storedResult, 64'h0);
    outcome(1'b0, CODE_OVF, 1'b0);
    load(16'h0480);
    result(1'b1, 10'h3FD, 55'h1234, 1'b0);
    check(storedResult[63:55], 9'h1FD);
    outcome(1'b1, CODE_UND, 1'b1);
    load(16'h0080);
    result(1'b1, 10'h3FD, 55'h1234, 1'b0);
    check(storedResult, 64'h0);
    outcome(1'b0, CODE_UND, 1'b0);
    $display("test range done");
    load(16'h00A0);
    result(1'b0, 10'h081, 55'h1, 1'b1);
    check(storedResult[54:0], 55'h1);
    load(16'h0080);
    result(1'b0, 10'h081, 55'h1, 1'b1);
    check(storedResult[54:0], 55'h2);
    load(16'h0020);
    result(1'b0, 10'h081, 55'h7FFFFFFFFFFFFF, 1'b0);
    check(storedResult[31:0], 32'h0);
    $display("test rounding done");
    complete_run;
  end
endmodule
